// ---- status_lamp_map.svh ----
// Register offsets, field positions and timing constants of the lamp block
`ifndef STATUS_LAMP_MAP_SVH
`define STATUS_LAMP_MAP_SVH

// Register byte offsets
`define CTRL_OFS    12'h000
`define STAT_OFS    12'h004

// Control register fields and reset value
`define CTRL_PROTO  1:0
`define PROTO_RST   2'h0

// Status register layout: lamps, latched faults, phase, links, lock
`define STAT_MOD    1:0
`define STAT_NET    3:2
`define STAT_FLT    8:4
`define STAT_PH     10:9
`define STAT_CONN   13:11
`define STAT_LOCK   14

// Clock rate and pattern timing
`define CLK_HZ      50000000
`define FLASH_MS    500
`define BLINK_MS    250
`define PAUSE_MS    2000
`define MS_CYC(ms)  ((ms) * (`CLK_HZ / 1000))
`define FLASH_CYC   `MS_CYC(`FLASH_MS)
`define BLINK_CYC   `MS_CYC(`BLINK_MS)
`define PAUSE_CYC   `MS_CYC(`PAUSE_MS)

// Pattern counts
`define ENC_BLINKS  2'h3
`define MAX_CONN    3'h5
`define WARM_DONE   2'h3

`endif

// ---- status_lamp_pkg.sv ----
// Types shared by the status lamp controller
package status_lamp_pkg;

    typedef logic [26:0] cnt_t;

    typedef enum logic [1:0]
    {
        PROTO_ENIP  = 2'h0,
        PROTO_MBTCP = 2'h1,
        PROTO_PNET  = 2'h2
    } proto_e;

    typedef enum logic [1:0]
    {
        ST_POWERUP = 2'h0,
        ST_ENC     = 2'h1,
        ST_RUN     = 2'h3
    } phase_e;

    typedef struct packed
    {
        logic red;
        logic green;
    } lamp_s;

    typedef struct packed
    {
        logic       comm_fail;
        logic       init_busy;
        logic       link_up;
        logic       flash_ok;
        logic       flash_fail;
        logic       proto_chg;
        logic       over_temp;
        logic       enc_err;
        logic       drive_ok;
        logic       cip_conn;
        logic       net_timeout;
        logic       name_ip_set;
        logic       dup_ip;
        logic       name_mismatch;
        logic       io_conn;
        logic       io_run;
        logic [2:0] conn_count;
    } cond_s;

    typedef struct packed
    {
        logic comm;
        logic flash_ok;
        logic flash_bad;
        logic proto_chg;
        logic over_temp;
    } fault_s;

    typedef struct packed
    {
        cond_s      s1;
        cond_s      s2;
        fault_s     f;
        phase_e     ph;
        proto_e     proto;
        logic [1:0] warm;
        cnt_t       fl_cnt;
        cnt_t       bl_cnt;
        cnt_t       pz_cnt;
        logic       fl_ph;
        logic       bl_ph;
        logic [1:0] enc_cnt;
        logic [3:0] mb_half;
        logic       mb_pause;
        lamp_s      ms;
        lamp_s      ns;
        logic [31:0] rdata;
    } st_s;

endpackage

// ---- status_lamp_ctrl.sv ----
// Status lamp controller for module and network health lamps
// Overview of operation
// - Comms failure: module lamp alternates until reset
// - Waiting for network link: module lamp flashes
// - Flash write done: green, commands refused
// - EtherNet/IP, Modbus: drive and network up, green
// - PROFINET: name or address set gives green
// - Protocol change: module flashes red, network flashes
// - Flash write failure: module flashes red, latched
// - Overtemperature: module lamp steady red, latched
// - Power-up initialisation: module lamp blinks green
// - Encoder error at power-up: three red blinks
// - EtherNet/IP: link flashes green, connections steady
// - EtherNet/IP protocol change: network flashes red
// - EtherNet/IP duplicate address: network steady red
// - Modbus: green groups per connection, 2 s pause
// - Modbus: off without connections, never steady green
// - PROFINET: off on conflict or no controller
// - PROFINET: controller stopped, network flashes green
// - PROFINET: controller running, network steady green
`timescale 1ns/1ns
`include "status_lamp_map.svh"
module status_lamp_ctrl
    import status_lamp_pkg::*;
#(
    parameter cnt_t FLASH_CYC = cnt_t'(`FLASH_CYC),
    parameter cnt_t BLINK_CYC = cnt_t'(`BLINK_CYC),
    parameter cnt_t PAUSE_CYC = cnt_t'(`PAUSE_CYC)
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Condition flags from the unit, asynchronous
    input  wire cond_s       cond_in,
    // Lamp drives and command lock
    output lamp_s            module_health_lamp,
    output lamp_s            network_health_lamp,
    output logic             cmd_lock
);

    st_s         st;
    st_s         n;
    cond_s       c;
    logic        fl_tick;
    logic        bl_tick;
    logic        blink_done;
    logic        setup;
    logic        access;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        wr_ctrl;
    logic        proto_wr;
    logic [2:0]  nconn;
    logic        mb_on;
    logic [31:0] stat;

    // Builds a lamp value from its two elements
    function automatic lamp_s lamp(input logic r, input logic g);
        lamp_s l;
        l.red   = r;
        l.green = g;
        return l;
    endfunction

    // Conditions after the two-flop synchroniser
    assign c = st.s2;

    // Prescaler terminal counts
    assign fl_tick    = st.fl_cnt == FLASH_CYC - cnt_t'(1);
    assign bl_tick    = st.bl_cnt == BLINK_CYC - cnt_t'(1);
    assign blink_done = bl_tick && st.bl_ph;

    // Modbus connection count, capped at the supported maximum
    assign nconn = (c.conn_count > `MAX_CONN) ? `MAX_CONN
                                              : c.conn_count;
    assign mb_on = !st.mb_pause && nconn != 3'h0 && !st.mb_half[0];

    // APB decode; control writes refused once locked, and only a
    // protocol change after power-up latches the change fault
    assign setup    = psel && !penable;
    assign access   = psel && penable;
    assign hit_ctrl = paddr == `CTRL_OFS;
    assign hit_stat = paddr == `STAT_OFS;
    assign wr_ctrl  = access && pwrite && hit_ctrl
                      && !st.f.flash_ok;
    assign proto_wr = wr_ctrl && pwdata[`CTRL_PROTO] != st.proto
                      && st.ph == ST_RUN;

    // Status word: lamps, faults, phase, connections, lock
    always_comb
    begin
        stat              = 32'h0;
        stat[`STAT_MOD]   = st.ms;
        stat[`STAT_NET]   = st.ns;
        stat[`STAT_FLT]   = st.f;
        stat[`STAT_PH]    = st.ph;
        stat[`STAT_CONN]  = c.conn_count;
        stat[`STAT_LOCK]  = st.f.flash_ok;
    end

    // Next state of the whole block
    always_comb
    begin
        n = st;
        n.s1 = cond_in;
        n.s2 = st.s1;

        // Faults latch until the next power-on reset
        n.f.comm      = st.f.comm | c.comm_fail;
        n.f.flash_ok  = st.f.flash_ok | c.flash_ok;
        n.f.flash_bad = st.f.flash_bad | c.flash_fail;
        n.f.proto_chg = st.f.proto_chg | c.proto_chg
                        | proto_wr;
        n.f.over_temp = st.f.over_temp | c.over_temp;

        // Flash and blink prescalers
        n.fl_cnt = fl_tick ? '0 : st.fl_cnt + cnt_t'(1);
        n.fl_ph  = st.fl_ph ^ fl_tick;
        n.bl_cnt = bl_tick ? '0 : st.bl_cnt + cnt_t'(1);
        n.bl_ph  = st.bl_ph ^ bl_tick;
        if (st.warm != `WARM_DONE)
        begin
            n.warm = st.warm + 2'h1;
        end

        // Power-up sequence, waits for synchronised flags
        case (st.ph)
            ST_POWERUP:
            begin
                if (st.warm == `WARM_DONE && c.enc_err)
                begin
                    n.ph      = ST_ENC;
                    n.bl_cnt  = '0;
                    n.bl_ph   = 1'b1;
                    n.enc_cnt = 2'h0;
                end
                else if (st.warm == `WARM_DONE && !c.init_busy)
                begin
                    n.ph = ST_RUN;
                end
            end
            ST_ENC:
            begin
                if (blink_done)
                begin
                    n.enc_cnt = st.enc_cnt + 2'h1;
                    if (st.enc_cnt == `ENC_BLINKS - 2'h1)
                    begin
                        n.ph = ST_RUN;
                    end
                end
            end
            ST_RUN:
            begin
                n.ph = ST_RUN;
            end
            default:
            begin
                n.ph = ST_POWERUP;
            end
        endcase

        // Modbus group sequencer: flash per connection, then pause
        if (st.mb_pause)
        begin
            n.pz_cnt = st.pz_cnt + cnt_t'(1);
            if (st.pz_cnt == PAUSE_CYC - cnt_t'(1))
            begin
                n.mb_pause = 1'b0;
                n.pz_cnt   = '0;
                n.mb_half  = 4'h0;
            end
        end
        else if (bl_tick)
        begin
            if (nconn == 3'h0)
            begin
                n.mb_half = 4'h0;
            end
            else if (st.mb_half >= {nconn, 1'b0} - 4'h1)
            begin
                n.mb_pause = 1'b1;
                n.mb_half  = 4'h0;
            end
            else
            begin
                n.mb_half = st.mb_half + 4'h1;
            end
        end

        // Module lamp, highest priority first
        if (st.f.comm)
        begin
            n.ms = lamp(st.fl_ph, !st.fl_ph);
        end
        else if (st.f.over_temp)
        begin
            n.ms = lamp(1'b1, 1'b0);
        end
        else if (st.f.flash_bad || st.f.proto_chg)
        begin
            n.ms = lamp(st.fl_ph, 1'b0);
        end
        else if (st.f.flash_ok)
        begin
            n.ms = lamp(1'b0, 1'b1);
        end
        else if (st.ph == ST_ENC)
        begin
            n.ms = lamp(st.bl_ph, 1'b0);
        end
        else if (st.ph != ST_RUN || c.init_busy)
        begin
            n.ms = lamp(1'b0, st.bl_ph);
        end
        else if (!c.link_up)
        begin
            n.ms = lamp(1'b0, st.fl_ph);
        end
        else if (st.proto == PROTO_PNET)
        begin
            n.ms = lamp(1'b0, c.name_ip_set | st.fl_ph);
        end
        else
        begin
            n.ms = lamp(1'b0, c.drive_ok | st.fl_ph);
        end

        // Network lamp, by protocol
        if (st.ph != ST_RUN)
        begin
            n.ns = lamp(st.fl_ph, !st.fl_ph);
        end
        else if (st.f.proto_chg)
        begin
            n.ns = lamp(st.fl_ph, 1'b0);
        end
        else
        begin
            case (st.proto)
                PROTO_MBTCP:
                begin
                    n.ns = lamp(1'b0, mb_on);
                end
                PROTO_PNET:
                begin
                    if (c.dup_ip || c.name_mismatch || !c.io_conn)
                    begin
                        n.ns = lamp(1'b0, 1'b0);
                    end
                    else if (c.io_run)
                    begin
                        n.ns = lamp(1'b0, 1'b1);
                    end
                    else
                    begin
                        n.ns = lamp(1'b0, st.fl_ph);
                    end
                end
                default:
                begin
                    if (c.dup_ip)
                    begin
                        n.ns = lamp(1'b1, 1'b0);
                    end
                    else if (c.net_timeout)
                    begin
                        n.ns = lamp(st.fl_ph, 1'b0);
                    end
                    else if (c.cip_conn)
                    begin
                        n.ns = lamp(1'b0, 1'b1);
                    end
                    else if (c.link_up)
                    begin
                        n.ns = lamp(1'b0, st.fl_ph);
                    end
                    else
                    begin
                        n.ns = lamp(1'b0, 1'b0);
                    end
                end
            endcase
        end

        // Register writes and read data capture in setup
        if (wr_ctrl)
        begin
            n.proto = proto_e'(pwdata[`CTRL_PROTO]);
        end
        if (setup && !pwrite)
        begin
            n.rdata = hit_ctrl ? {30'h0, st.proto}
                    : hit_stat ? stat : 32'h0;
        end
    end

    // State register; everything clears on power-on reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= n;
        end
    end

    // Outputs
    assign module_health_lamp  = st.ms;
    assign network_health_lamp = st.ns;
    assign cmd_lock            = st.f.flash_ok;
    assign prdata              = st.rdata;
    assign pready              = 1'b1;
    assign pslverr             = access && ((!hit_ctrl && !hit_stat)
                                 || (pwrite && hit_ctrl
                                     && st.f.flash_ok));

    // Checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_comm_alt;
        st.f.comm |=> module_health_lamp.red != module_health_lamp.green;
    endproperty
    a_comm_alt: assert property (p_comm_alt)
        else $error("Module lamp not alternating on comms failure");

    property p_comm_hold;
        st.f.comm |=> st.f.comm [*4];
    endproperty
    a_comm_hold: assert property (p_comm_hold)
        else $error("Comms failure flag cleared without reset");

    property p_hot;
        st.f.over_temp && !st.f.comm
            |=> module_health_lamp.red && !module_health_lamp.green;
    endproperty
    a_hot: assert property (p_hot)
        else $error("Module lamp not steady red on overtemperature");

    property p_lock;
        access && pwrite && hit_ctrl && st.f.flash_ok
            |-> pslverr ##1 st.proto == $past(st.proto);
    endproperty
    a_lock: assert property (p_lock)
        else $error("Control write taken while locked");

    property p_enc_end;
        st.ph == ST_ENC && blink_done && st.enc_cnt == 2'h2
            |=> st.ph == ST_RUN;
    endproperty
    a_enc_end: assert property (p_enc_end)
        else $error("Encoder blinks did not end after three");

    property p_eip_dup;
        st.ph == ST_RUN && st.proto == PROTO_ENIP && c.dup_ip
            && !st.f.proto_chg
            |=> network_health_lamp.red && !network_health_lamp.green;
    endproperty
    a_eip_dup: assert property (p_eip_dup)
        else $error("Network lamp not red on duplicate address");

    property p_pn_run;
        st.ph == ST_RUN && st.proto == PROTO_PNET && !st.f.proto_chg
            && c.io_conn && c.io_run && !c.dup_ip && !c.name_mismatch
            |=> network_health_lamp == lamp(1'b0, 1'b1);
    endproperty
    a_pn_run: assert property (p_pn_run)
        else $error("Network lamp not green in run state");

    property p_pn_off;
        st.ph == ST_RUN && st.proto == PROTO_PNET && !st.f.proto_chg
            && (c.dup_ip || c.name_mismatch || !c.io_conn)
            |=> network_health_lamp == lamp(1'b0, 1'b0);
    endproperty
    a_pn_off: assert property (p_pn_off)
        else $error("Network lamp not off without controller");

    property p_mb_off;
        st.ph == ST_RUN && st.proto == PROTO_MBTCP && !st.f.proto_chg
            && nconn == 3'h0
            |=> network_health_lamp == lamp(1'b0, 1'b0);
    endproperty
    a_mb_off: assert property (p_mb_off)
        else $error("Network lamp lit without connections");

    property p_mb_pause;
        $rose(st.mb_pause) && st.ph == ST_RUN && st.proto == PROTO_MBTCP
            && !st.f.proto_chg
            |=> !network_health_lamp.green [*8];
    endproperty
    a_mb_pause: assert property (p_mb_pause)
        else $error("Network lamp lit during group pause");

    property p_flash;
        fl_tick |=> st.fl_ph != $past(st.fl_ph) && st.fl_cnt == '0;
    endproperty
    a_flash: assert property (p_flash)
        else $error("Flash phase did not toggle at terminal count");

    c_enc_done: cover property (st.ph == ST_ENC ##1 st.ph == ST_RUN);
    c_mb_group: cover property ($rose(st.mb_pause));
    c_lock_wr:  cover property (access && pwrite && st.f.flash_ok);
    c_pn_run:   cover property (st.proto == PROTO_PNET
                                && network_health_lamp.green);

endmodule

// ---- lamp_watch.sv ----
// Observer model of one bicolour indicator lamp, counting lit cycles
`timescale 1ns/1ns
module lamp_watch
    import status_lamp_pkg::*;
(
    // Clock and window clear
    input  wire logic        pclk,
    input  wire logic        clr,
    // Lamp drive, active high per colour
    input  wire lamp_s       lamp,
    // Counts gathered over the window
    output logic      [15:0] red_on,
    output logic      [15:0] grn_on,
    output logic      [15:0] red_rise
);
    logic prev_red;

    // An element glows in every cycle its drive is high
    always_ff @(posedge pclk)
    begin
        prev_red <= lamp.red;
        if (clr)
        begin
            red_on   <= 16'h0000;
            grn_on   <= 16'h0000;
            red_rise <= 16'h0000;
        end
        else
        begin
            red_on   <= red_on + 16'(lamp.red);
            grn_on   <= grn_on + 16'(lamp.green);
            red_rise <= red_rise + 16'(lamp.red & ~prev_red);
        end
    end
endmodule

// ---- status_lamp_controller_bench.sv ----
// Self-checking bench of the status lamp controller
`timescale 1ns/1ns
`include "status_lamp_map.svh"
module status_lamp_controller_bench
    import status_lamp_pkg::*;
;
    localparam int W = 48;
    localparam int BL = 4, PZ = 16;
    localparam logic [2:0] OFF = 3'h0, GRN = 3'h1, GFL = 3'h2;
    localparam logic [2:0] RED = 3'h3, RFL = 3'h4, ALT = 3'h5;

    logic        pclk, presetn, psel, penable, pwrite, cmd_lock, clr;
    logic        pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        err;
    cond_s       cond, c;
    lamp_s       ms, ns;
    logic [15:0] ms_r, ms_g, ms_rise, ns_r, ns_g;
    logic [3:0]  mask;
    logic [3:0]  tab [7] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC};
    int          mismatches, compares;
    int unsigned seed_v;
    int          nc;
    logic [31:0] wd;

    // Short prescalers keep the patterns a few cycles long
    status_lamp_ctrl #(.FLASH_CYC(27'h8), .BLINK_CYC(27'h4),
                       .PAUSE_CYC(27'h10)) dut_u (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cond_in(cond), .module_health_lamp(ms),
        .network_health_lamp(ns), .cmd_lock(cmd_lock));

    // Lamp models on both drives
    lamp_watch ms_w (.pclk(pclk), .clr(clr), .lamp(ms), .red_on(ms_r),
                     .grn_on(ms_g), .red_rise(ms_rise));
    lamp_watch ns_w (.pclk(pclk), .clr(clr), .lamp(ns), .red_on(ns_r),
                     .grn_on(ns_g), .red_rise());

    // 50 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 50)
        begin
            mismatches++;
            tally_and_finish();
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Pattern seen over a window of W cycles
    function automatic logic [2:0] pat(input logic [15:0] r, g);
        if (r == 0 && g == 0)
            return OFF;
        if (r == 0)
            return (g == W) ? GRN : GFL;
        if (g == 0)
            return (r == W) ? RED : RFL;
        return ALT;
    endfunction

    // Module lamp choice by fault priority, drive and network up
    function automatic logic [2:0] expect_ms(input cond_s f);
        if (f.comm_fail)
            return ALT;
        if (f.over_temp)
            return RED;
        if (f.flash_fail)
            return RFL;
        return GRN;
    endfunction

    function automatic cond_s base();
        cond_s b;
        b = '0;
        b.link_up = 1'b1;
        b.drive_ok = 1'b1;
        b.cip_conn = 1'b1;
        b.conn_count = 3'($urandom_range(5, 0));
        return b;
    endfunction

    task automatic obs(input int n);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    task automatic see(input string nm, input logic [2:0] em, en,
                       input logic use_ns);
        obs(W);
        chk(nm, 32'(em), 32'(pat(ms_r, ms_g)));
        if (use_ns)
            chk(nm, 32'(en), 32'(pat(ns_r, ns_g)));
        @(posedge pclk);
    endtask

    // Reset with given flags, lamps dark while held
    task automatic restart(input cond_s f, input int settle);
        @(posedge pclk);
        presetn <= 1'b0;
        cond    <= f;
        repeat (4) @(posedge pclk);
        chk("lamps in reset", 32'h0, 32'({ms, ns}));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (settle) @(posedge pclk);
    endtask

    // Reset into power-up, set the protocol, then let init finish
    task automatic boot(input cond_s f, input logic [1:0] p);
        f.init_busy = 1'b1;
        restart(f, 20);
        apb(1'b1, `CTRL_OFS, {30'h0, p});
        f.init_busy = 1'b0;
        cond <= f;
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cond = '0;
        clr = 1'b0;
        mismatches = 0;
        compares = 0;
        seed_v = $urandom(32'h4E0FA5F7);
        // Power-up, link and network states
        c = base();
        c.init_busy = 1'b1;
        restart(c, 20);
        see("init", GFL, ALT, 1'b1);
        c.init_busy = 1'b0;
        c.link_up = 1'b0;
        cond <= c;
        repeat (10) @(posedge pclk);
        see("no link", GFL, OFF, 1'b0);
        c.link_up = 1'b1;
        c.cip_conn = 1'b0;
        cond <= c;
        repeat (10) @(posedge pclk);
        see("link only", GRN, GFL, 1'b1);
        c.cip_conn = 1'b1;
        cond <= c;
        repeat (10) @(posedge pclk);
        see("connected", GRN, GRN, 1'b1);
        c.dup_ip = 1'b1;
        cond <= c;
        repeat (10) @(posedge pclk);
        see("dup addr", GRN, RED, 1'b1);
        c.dup_ip = 1'b0;
        c.net_timeout = 1'b1;
        cond <= c;
        repeat (10) @(posedge pclk);
        see("timeout", GRN, RFL, 1'b1);
        // Encoder error gives three red blinks
        c = base();
        c.enc_err = 1'b1;
        restart(c, 0);
        obs(80);
        chk("enc blinks", 32'h3, 32'(ms_rise));
        // Latched faults, hand picked then random
        for (int k = 0; k < 12; k++)
        begin
            mask = (k < 7) ? tab[k] : 4'($urandom_range(15, 1));
            restart(base(), 20);
            c = base();
            c.comm_fail = mask[0];
            c.over_temp = mask[1];
            c.flash_fail = mask[2];
            c.flash_ok = mask[3];
            cond <= c;
            repeat (10) @(posedge pclk);
            cond <= base();
            repeat (10) @(posedge pclk);
            see("fault", expect_ms(c), GRN,
                mask[1:0] == 2'h0);
            chk("lock", 32'(mask[3]), 32'(cmd_lock));
            wd = (32'($urandom) & 32'hFFFFFFFC) | 32'h1;
            apb(1'b1, `CTRL_OFS, wd);
            chk("ctrl refused", 32'(mask[3]), 32'(err));
            apb(1'b0, `CTRL_OFS, 32'h0);
            chk("ctrl kept", mask[3] ? 32'h0 : wd & 32'h3,
                rd & 32'h3);
        end
        // PROFINET: controller running, stopped, then absent
        c = base();
        c.name_ip_set = 1'b1;
        c.io_conn = 1'b1;
        c.io_run = 1'b1;
        boot(c, 2'h2);
        repeat (10) @(posedge pclk);
        see("pn run", GRN, GRN, 1'b1);
        c.io_run = 1'b0;
        cond <= c;
        repeat (10) @(posedge pclk);
        see("pn stop", GRN, GFL, 1'b1);
        c.io_conn = 1'b0;
        c.name_ip_set = 1'b0;
        cond <= c;
        repeat (10) @(posedge pclk);
        see("pn none", GFL, OFF, 1'b1);
        // Modbus: dark without links, then groups over two periods
        c = base();
        c.conn_count = 3'h0;
        boot(c, 2'h1);
        repeat (10) @(posedge pclk);
        see("mb none", GRN, OFF, 1'b1);
        for (int k = 0; k < 3; k++)
        begin
            c.conn_count = 3'($urandom_range(7, 1));
            nc = (c.conn_count > 3'h5) ? 5 : int'(c.conn_count);
            cond <= c;
            repeat (120) @(posedge pclk);
            // One on and one off half per link, then the pause
            obs(2 * (2 * BL * nc + PZ));
            chk("mb green", 32'(2 * BL * nc), 32'(ns_g));
            chk("mb red", 32'h0, 32'(ns_r));
            @(posedge pclk);
        end
        // Registers and protocol change
        restart(base(), 20);
        apb(1'b0, `CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h0, rd & 32'h3);
        apb(1'b0, 12'h008, 32'h0);
        chk("unmapped data", 32'h0, rd);
        chk("unmapped err", 32'h1, 32'(err));
        apb(1'b1, `STAT_OFS, 32'hFFFFFFFF);
        chk("stat write err", 32'h0, 32'(err));
        apb(1'b1, `CTRL_OFS, 32'h1);
        chk("ctrl write err", 32'h0, 32'(err));
        apb(1'b0, `CTRL_OFS, 32'h0);
        chk("ctrl proto", 32'h1, rd & 32'h3);
        repeat (10) @(posedge pclk);
        apb(1'b0, `STAT_OFS, 32'h0);
        chk("proto fault", 32'h1, 32'(rd[5]));
        see("proto chg", RFL, RFL, 1'b1);
        tally_and_finish();
    end
endmodule
